// file: verilog/sgsel_top.sv
// setting group selector: ahb-lite registers, input sync, stage enables
// assumes one ahb-lite master, pins asynchronous to hclk
`timescale 1ns/100ps
`default_nettype none

module sgsel_top
  import sgsel_pkg::*;
#(
  parameter int MAX_ENABLED_P = MAX_ENABLED
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // control pins
  input wire logic [NUM_DI-1:0] digital_input,
  input wire logic [NUM_FKEY-1:0] function_key,
  // results
  output logic [1:0] active_group,
  output logic [NUM_STAGES-1:0] stage_enable
);

  localparam logic [5:0] LIMIT_C = 6'(MAX_ENABLED_P);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [NUM_DI-1:0] di_meta_reg;
  logic [NUM_DI-1:0] di_sync_reg;
  logic [NUM_FKEY-1:0] fk_meta_reg;
  logic [NUM_FKEY-1:0] fk_sync_reg;
  sgsel_ctrl_t ctrl_reg;
  sgsel_ctrl_t ctrl_next;
  sgsel_assign_set_t assign_reg;
  sgsel_assign_set_t assign_next;
  logic [NUM_VIRT-1:0] virt_reg;
  logic [NUM_VIRT-1:0] virt_next;
  logic [NUM_STAGES-1:0] stage_reg;
  logic [NUM_STAGES-1:0] stage_next;
  logic refused_reg;
  logic refused_next;
  logic [1:0] active_reg;
  logic [1:0] active_next;
  sgsel_aphase_t dp_reg;
  sgsel_aphase_t dp_next;
  logic [31:0] hrdata_reg;
  logic [31:0] hrdata_next;
  logic hreadyout_reg;
  logic hresp_reg;
  logic [NUM_SRC-1:0] sources;
  logic [SGSEL_GROUPS-1:0] grp_mask;
  logic [1:0] grp_idx;
  logic [5:0] wr_count;
  logic [5:0] en_count;
  logic refuse_set;
  logic refuse_clr;
  logic addr_hit;

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  // two flops on every pin before the resolver reads it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      di_meta_reg <= '0;
      di_sync_reg <= '0;
      fk_meta_reg <= '0;
      fk_sync_reg <= '0;
    end else begin
      di_meta_reg <= digital_input;
      di_sync_reg <= di_meta_reg;
      fk_meta_reg <= function_key;
      fk_sync_reg <= fk_meta_reg;
    end
  end

  // ---------------------------------------------------------------
  // group resolution
  // ---------------------------------------------------------------
  // virtual inputs sit above function keys and digital inputs
  assign sources = {virt_reg, fk_sync_reg, di_sync_reg};

  sgsel_resolve u_resolve (
    .sources(sources),
    .group_input_assignment(assign_reg),
    .ctrl(ctrl_reg),
    .group_mask(grp_mask),
    .group_idx(grp_idx)
  );

  // ---------------------------------------------------------------
  // register file and bus next state
  // ---------------------------------------------------------------
  // writes commit in the data phase; reads are formed from next values
  // so a read right behind a write already sees the new contents
  always_comb begin
    ctrl_next = ctrl_reg;
    assign_next = assign_reg;
    virt_next = virt_reg;
    stage_next = stage_reg;
    refuse_set = 1'b0;
    refuse_clr = 1'b0;
    wr_count = sgsel_popcount(hwdata);
    active_next = grp_idx;
    addr_hit = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0);
    dp_next.wr = hsel && hready && htrans[1] && hwrite && addr_hit;
    dp_next.rd = hsel && hready && htrans[1] && !hwrite && addr_hit;
    dp_next.addr = haddr[7:0];
    if (dp_reg.wr) begin
      case (dp_reg.addr)
        OFS_CTRL: begin
          ctrl_next = sgsel_ctrl_t'(hwdata[CTRL_W-1:0]);
        end
        OFS_ASSIGN: begin
          assign_next = sgsel_assign_set_t'(hwdata[ASSIGN_W-1:0]);
        end
        OFS_VIRT: begin
          virt_next = hwdata[NUM_VIRT-1:0];
        end
        OFS_STAGE: begin
          if (wr_count <= LIMIT_C) begin
            stage_next = hwdata;
          end else begin
            refuse_set = 1'b1;
          end
        end
        OFS_STATUS: begin
          refuse_clr = hwdata[STAT_REFUSED_BIT];
        end
        default: begin
        end
      endcase
    end
    // a refusal in the clearing cycle keeps the flag set
    refused_next = refuse_set || (refused_reg && !refuse_clr);
    en_count = sgsel_popcount(stage_next);
    hrdata_next = 32'h00000000;
    if (dp_next.rd) begin
      case (dp_next.addr)
        OFS_CTRL: hrdata_next = {29'h00000000, ctrl_next};
        OFS_ASSIGN: hrdata_next = {8'h00, assign_next};
        OFS_VIRT: hrdata_next = {20'h00000, virt_next};
        OFS_STAGE: hrdata_next = stage_next;
        OFS_STATUS: begin
          hrdata_next = {10'h000, en_count, 7'h00, refused_next,
                         grp_mask, 2'h0, active_reg};
        end
        default: hrdata_next = 32'h00000000;
      endcase
    end
  end

  // registers of the file, the bus and the outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= RST_CTRL;
      assign_reg <= sgsel_assign_set_t'(RST_ASSIGN);
      virt_reg <= RST_VIRT;
      stage_reg <= RST_STAGE;
      refused_reg <= 1'b0;
      active_reg <= 2'h0;
      dp_reg <= '0;
      hrdata_reg <= 32'h00000000;
      hreadyout_reg <= 1'b1;
      hresp_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      assign_reg <= assign_next;
      virt_reg <= virt_next;
      stage_reg <= stage_next;
      refused_reg <= refused_next;
      active_reg <= active_next;
      dp_reg <= dp_next;
      hrdata_reg <= hrdata_next;
      hreadyout_reg <= 1'b1;
      hresp_reg <= 1'b0;
    end
  end

  // outputs straight from flops
  assign hreadyout = hreadyout_reg;
  assign hresp = hresp_reg;
  assign hrdata = hrdata_reg;
  assign active_group = active_reg;
  assign stage_enable = stage_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // data phase of a write to a given register; over-limit stage word on hwdata
  sequence s_stage_wr;
    dp_reg.wr && (dp_reg.addr == OFS_STAGE);
  endsequence

  sequence s_over_limit;
    sgsel_popcount(hwdata) > LIMIT_C;
  endsequence

  sequence s_virt_wr;
    dp_reg.wr && (dp_reg.addr == OFS_VIRT);
  endsequence

  sequence s_assign_wr;
    dp_reg.wr && (dp_reg.addr == OFS_ASSIGN);
  endsequence

  AST_VIRT_SOURCE: assert property (
    s_virt_wr |=> (virt_reg == $past(hwdata[NUM_VIRT-1:0])))
    else $error("virtual input write not taken");

  AST_ASSIGN_TAKEN: assert property (
    s_assign_wr |=> (assign_reg == $past(hwdata[ASSIGN_W-1:0])))
    else $error("group assignment write not taken");

  AST_DEFAULT_GROUP: assert property (
    (grp_mask == 4'h0) |=> (active_group == $past(ctrl_reg.dflt)))
    else $error("default group not selected");

  AST_SINGLE_GROUP: assert property (
    $onehot(grp_mask) |=> ($past(grp_mask) == (4'h1 << active_group)))
    else $error("single request did not select its group");

  // descending: nothing requested above the winner; ascending: below it
  AST_MULTI_PRIORITY: assert property (
    ($countones(grp_mask) > 1) |=>
      (($past(ctrl_reg.order) == SGSEL_DESCENDING) ?
        (($past(grp_mask) >> active_group) == 4'h1) :
        (($past(grp_mask) << (2'h3 - active_group)) == 4'h8)))
    else $error("several requests resolved wrongly");

  AST_ORDER_EDGE: assert property (
    ((grp_mask == 4'hF) && (ctrl_reg.order == SGSEL_DESCENDING))
      |=> (active_group == 2'h3))
    else $error("descending order did not pick highest group");

  AST_WORKED_ASC: assert property (
    ((grp_mask == 4'h6) && (ctrl_reg.order == SGSEL_ASCENDING))
      |=> (active_group == 2'h1))
    else $error("groups two and three ascending did not give two");

  AST_WORKED_DESC: assert property (
    ((grp_mask == 4'h6) && (ctrl_reg.order == SGSEL_DESCENDING))
      |=> (active_group == 2'h2))
    else $error("groups two and three descending did not give three");

  AST_STAGE_TAKEN: assert property (
    (s_stage_wr ##0 !(sgsel_popcount(hwdata) > LIMIT_C))
      |=> (stage_enable == $past(hwdata)))
    else $error("stage enable write not taken");

  AST_STAGE_REFUSED: assert property (
    (s_stage_wr ##0 s_over_limit) |=> ($stable(stage_enable) && refused_reg))
    else $error("over-limit stage write not refused");

  AST_STAGE_LIMIT: assert property (
    sgsel_popcount(stage_enable) <= LIMIT_C)
    else $error("enabled stage count above limit");

  AST_FOLLOW_NEXT: assert property (
    $changed(grp_idx) |=> (active_group == $past(grp_idx)))
    else $error("active group did not follow in one cycle");

endmodule

`default_nettype wire

// file: verilog/sgsel_pkg.sv
// setting group selector: shared constants, carrier types and helpers
// assumes one clock domain and a 32-bit ahb-lite register bus
`default_nettype none

package sgsel_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int SGSEL_GROUPS = 4;
  localparam int NUM_DI = 16;
  localparam int NUM_FKEY = 4;
  localparam int NUM_VIRT = 12;
  localparam int NUM_SRC = 32;
  localparam int NUM_STAGES = 32;
  localparam int MAX_ENABLED = 30;
  localparam int SYNC_CYCLES = 2;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ASSIGN = 8'h04;
  localparam logic [7:0] OFS_VIRT = 8'h08;
  localparam logic [7:0] OFS_STAGE = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CTRL_W = 3;
  localparam int ASSIGN_W = 24;
  localparam int STAT_MASK_LSB = 4;
  localparam int STAT_REFUSED_BIT = 8;
  localparam int STAT_COUNT_LSB = 16;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic {
    SGSEL_ASCENDING = 1'b0,
    SGSEL_DESCENDING = 1'b1
  } sgsel_order_t;

  // control word: priority order and default group
  typedef struct packed {
    sgsel_order_t order;
    logic [1:0] dflt;
  } sgsel_ctrl_t;

  // one group's input assignment: used flag and source index
  typedef struct packed {
    logic used;
    logic [4:0] src;
  } sgsel_assign_t;

  typedef sgsel_assign_t [SGSEL_GROUPS-1:0] sgsel_assign_set_t;

  // captured ahb address phase
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
  } sgsel_aphase_t;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam sgsel_ctrl_t RST_CTRL = '{order: SGSEL_ASCENDING, dflt: 2'h0};
  localparam logic [ASSIGN_W-1:0] RST_ASSIGN = 24'h000000;
  localparam logic [NUM_VIRT-1:0] RST_VIRT = 12'h000;
  localparam logic [NUM_STAGES-1:0] RST_STAGE = 32'h00000000;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // number of set bits in a stage enable word
  function automatic logic [5:0] sgsel_popcount(input logic [31:0] v);
    logic [5:0] n;
    n = 6'h00;
    for (int i = 0; i < 32; i++) begin
      n = n + {5'h00, v[i]};
    end
    return n;
  endfunction

  // winning group among several asserted ones
  function automatic logic [1:0] sgsel_pick(input logic [3:0] mask,
                                            input sgsel_order_t order);
    logic [1:0] idx;
    idx = 2'h0;
    if (order == SGSEL_ASCENDING) begin
      for (int i = 3; i >= 0; i--) begin
        if (mask[i]) idx = 2'(i);
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (mask[i]) idx = 2'(i);
      end
    end
    return idx;
  endfunction

endpackage

`default_nettype wire

// file: verilog/sgsel_resolve.sv
// setting group selector: combinational group resolver
// assumes synchronised sources and registered settings on its inputs
`timescale 1ns/100ps
`default_nettype none

module sgsel_resolve
  import sgsel_pkg::*;
(
  // control sources and settings
  input wire logic [NUM_SRC-1:0] sources,
  input wire sgsel_assign_set_t group_input_assignment,
  input wire sgsel_ctrl_t ctrl,
  // result
  output logic [SGSEL_GROUPS-1:0] group_mask,
  output logic [1:0] group_idx
);

  // ---------------------------------------------------------------
  // group request decode and resolution
  // ---------------------------------------------------------------
  // a group requests when it is marked used and its assigned source is high
  always_comb begin
    group_mask = '0;
    for (int g = 0; g < SGSEL_GROUPS; g++) begin
      group_mask[g] = group_input_assignment[g].used &&
                      sources[group_input_assignment[g].src];
    end
    if (group_mask == 4'h0) begin
      group_idx = ctrl.dflt;
    end else begin
      group_idx = sgsel_pick(group_mask, ctrl.order);
    end
  end

endmodule

`default_nettype wire

// file: testbench/sgsel_pins_model.sv
// pin model for the control sources of the setting group selector
// assumes the bench commands the levels; pins are plain active-high levels
`timescale 1ns/100ps
`default_nettype none

module sgsel_pins_model
  import sgsel_pkg::*;
(
  // clock and answer speed
  input wire logic hclk,
  input wire logic slow,
  // commanded levels
  input wire logic [NUM_DI-1:0] di_cmd,
  input wire logic [NUM_FKEY-1:0] fk_cmd,
  // pins towards the device
  output logic [NUM_DI-1:0] digital_input,
  output logic [NUM_FKEY-1:0] function_key
);
  // -----------------------------------------------------------------
  // pin drive
  // -----------------------------------------------------------------
  logic [NUM_DI-1:0] di_dly;
  logic [NUM_FKEY-1:0] fk_dly;

  // start from all pins released low
  initial begin
    di_dly = '0;
    fk_dly = '0;
    digital_input = '0;
    function_key = '0;
  end

  // inputs and keys follow the command, a cycle later when slow
  always @(posedge hclk) begin
    di_dly <= di_cmd;
    fk_dly <= fk_cmd;
    digital_input <= slow ? di_dly : di_cmd;
    function_key <= slow ? fk_dly : fk_cmd;
  end
endmodule

`default_nettype wire

// file: testbench/tb.sv
// self-checking bench for the setting group selector
// assumes the design package and the pin model are compiled first
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
  err_total++; $display("FAIL %s exp %h got %h", nm, ex, got); end end

module tb;
  import sgsel_pkg::*;
  // -----------------------------------------------------------------
  // signals
  // -----------------------------------------------------------------
  localparam int LIM = 3;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h00000000;
  logic hready;
  logic hresp;
  logic [31:0] hrdata;
  logic [NUM_DI-1:0] digital_input;
  logic [NUM_FKEY-1:0] function_key;
  logic [NUM_DI-1:0] di_cmd = '0;
  logic [NUM_FKEY-1:0] fk_cmd = '0;
  logic slow = 1'b0;
  logic [1:0] active_group;
  logic [NUM_STAGES-1:0] stage_enable;
  int err_total = 0;
  int cmp_count = 0;
  logic [31:0] rd, virt, asg, ctl, stg, w;

  // 200 MHz clock
  always #2.5 hclk = ~hclk;

  // -----------------------------------------------------------------
  // design and pin model
  // -----------------------------------------------------------------
  sgsel_top #(.MAX_ENABLED_P(LIM)) dut_u (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .digital_input(digital_input),
    .function_key(function_key), .active_group(active_group),
    .stage_enable(stage_enable));

  sgsel_pins_model pins_u (.hclk(hclk), .slow(slow), .di_cmd(di_cmd),
    .fk_cmd(fk_cmd), .digital_input(digital_input),
    .function_key(function_key));

  // -----------------------------------------------------------------
  // tasks and expectations
  // -----------------------------------------------------------------
  // counts, verdict and end of run
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // bounded wait for hready sampled high at a rising edge
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      err_total++;
      $display("FAIL hready exp 1 got %b", hready);
      end_of_test();
    end
  endtask

  // one single word transfer; read data lands in rd
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    htrans <= 2'h2;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    `CHK("hresp", 1'b0, hresp)
  endtask

  // groups marked used whose assigned source is active
  function automatic logic [3:0] exp_mask(input logic [31:0] s,
                                          input logic [23:0] as);
    logic [3:0] m;
    for (int g = 0; g < 4; g++) begin
      m[g] = as[6*g+5] & s[as[6*g +: 5]];
    end
    return m;
  endfunction

  // winning group: default when none, else lowest or highest
  function automatic logic [1:0] exp_grp(input logic [31:0] s,
                                         input logic [23:0] as,
                                         input logic [2:0] c);
    logic [3:0] m;
    logic [1:0] g;
    int k;
    m = exp_mask(s, as);
    g = c[1:0];
    for (int i = 0; i < 4; i++) begin
      k = c[2] ? i : 3 - i;
      if (m[k]) g = 2'(k);
    end
    return g;
  endfunction

  // settle pins, then compare the active group and the status word
  task automatic grp_chk();
    logic [31:0] s;
    logic [1:0] g;
    // wait first: pin commands given by nonblocking assignment must land
    repeat (7) @(posedge hclk);
    s = {virt[11:0], fk_cmd, di_cmd};
    g = exp_grp(s, asg[23:0], ctl[2:0]);
    `CHK("active_group", g, active_group)
    bus(1'b0, OFS_STATUS, 32'h00000000);
    `CHK("status_mask", exp_mask(s, asg[23:0]), rd[7:4])
    `CHK("status_group", g, rd[1:0])
  endtask

  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    void'($urandom(32'h2DD121DA));
    virt = 32'h00000000;
    asg = 32'h00000000;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    // reset contents and an unmapped place
    bus(1'b0, OFS_CTRL, 32'h0);
    `CHK("ctrl_rst", 32'h00000000, rd)
    bus(1'b0, OFS_ASSIGN, 32'h0);
    `CHK("assign_rst", 32'h00000000, rd)
    bus(1'b0, OFS_STAGE, 32'h0);
    `CHK("stage_rst", 32'h00000000, rd)
    bus(1'b1, 8'h14, 32'hFFFFFFFF);
    bus(1'b0, 8'h14, 32'h0);
    `CHK("unmapped", 32'h00000000, rd)
    $display("test reset done");
    // default group follows the register one edge after the write
    for (int d = 0; d < 4; d++) begin
      bus(1'b1, OFS_CTRL, 32'(d));
      repeat (2) @(posedge hclk);
      `CHK("default_group", 2'(d), active_group)
    end
    $display("test default done");
    // inputs 0..3 control groups 1..4; two and three together
    for (int g = 0; g < 4; g++) begin
      asg[6*g +: 6] = {1'b1, 5'(g)};
    end
    bus(1'b1, OFS_ASSIGN, asg);
    di_cmd <= 16'h0006;
    for (int o = 0; o < 2; o++) begin
      ctl = {29'h0, o[0], 2'h3};
      bus(1'b1, OFS_CTRL, ctl);
      repeat (7) @(posedge hclk);
      `CHK("pair_group", o ? 2'h2 : 2'h1, active_group)
    end
    di_cmd <= 16'h0008;
    grp_chk();
    di_cmd <= 16'h0000;
    grp_chk();
    $display("test priority done");
    // random assignments, sources, settings and model speed
    for (int n = 0; n < 40; n++) begin
      ctl = $urandom & 32'h7;
      asg = $urandom & 32'h00FFFFFF;
      virt = $urandom & 32'h00000FFF;
      slow <= 1'($urandom);
      di_cmd <= 16'($urandom & $urandom);
      fk_cmd <= 4'($urandom);
      bus(1'b1, OFS_CTRL, ctl);
      bus(1'b1, OFS_ASSIGN, asg);
      bus(1'b1, OFS_VIRT, virt);
      grp_chk();
    end
    $display("test random groups done");
    // stage enables against the limit
    bus(1'b1, OFS_STAGE, 32'h00000007);
    @(posedge hclk);
    `CHK("stage_ok", 32'h00000007, stage_enable)
    bus(1'b1, OFS_STAGE, 32'h0000000F);
    @(posedge hclk);
    `CHK("stage_refused", 32'h00000007, stage_enable)
    bus(1'b0, OFS_STATUS, 32'h0);
    `CHK("status_ref", 32'h00030100, rd & 32'h003F0100)
    bus(1'b1, OFS_STATUS, 32'h00000100);
    bus(1'b0, OFS_STATUS, 32'h0);
    `CHK("refused_clear", 1'b0, rd[8])
    stg = 32'h00000007;
    for (int n = 0; n < 30; n++) begin
      w = $urandom & $urandom & $urandom;
      if ($countones(w) <= LIM) stg = w;
      bus(1'b1, OFS_STAGE, w);
      @(posedge hclk);
      `CHK("stage_rand", stg, stage_enable)
    end
    $display("test stages done");
    // reset in mid-run: settings and enables fall back to reset values
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    `CHK("stage_mid_rst", 32'h00000000, stage_enable)
    `CHK("group_mid_rst", 2'h0, active_group)
    bus(1'b0, OFS_CTRL, 32'h0);
    `CHK("ctrl_mid_rst", 32'h00000000, rd)
    $display("test mid reset done");
    end_of_test();
  end
endmodule

`default_nettype wire
